// >>> ddr_trap_aging_pkg.sv
// constants and carrier types for the command aging and access trap block
// Operation
// - After the programmed transfer count completes, raise priority of the oldest queued command.
// - Threshold value N means N+1 transfers; FEh gives 255 transfers.
// - Threshold FFh disables priority raising entirely.
// - An illegal access sets the raw trap bit 2 regardless of enable.
// - Writing 1 to raw bit clears raw and masked bits; 0 does nothing.
// - Masked bit sets only when a trap occurs while enabled.
// - Writing 1 to masked bit clears masked and raw bits; 0 does nothing.
// - Writing 1 to enable-set sets shared enable, read through set and clear views.
// - Simultaneous enable-set and enable-clear writes leave the trap interrupt disabled.
// - After an enable-clear write of 1 the enable-set bit reads 0.
// - Writing 1 to enable-clear clears the shared enable; 0 does nothing.
package ddr_trap_aging_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_AGING_THRESHOLD = 8'h00;
    localparam logic [7:0] OFF_TRAP_RAW        = 8'h04;
    localparam logic [7:0] OFF_TRAP_MASKED     = 8'h08;
    localparam logic [7:0] OFF_TRAP_EN_SET     = 8'h0C;
    localparam logic [7:0] OFF_TRAP_EN_CLEAR   = 8'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // field layout
    localparam int THRESHOLD_W   = 8;
    localparam int TRAP_BIT      = 2;
    localparam logic [7:0] THRESHOLD_DISABLED = 8'hFF;
    localparam logic [31:0] THRESHOLD_FIELD_MASK = 32'h000000FF;
    localparam logic [31:0] TRAP_FIELD_MASK      = 32'h00000004;

    // reset values
    localparam logic [7:0]  THRESHOLD_RESET = 8'hFF;
    localparam logic [7:0]  COUNT_RESET     = 8'h00;
    localparam logic [31:0] RDATA_IDLE      = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_type;

    typedef struct packed {
        logic clear_status;
        logic enable_set;
        logic enable_clear;
    } trap_ctrl_type;

    typedef struct packed {
        logic raw;
        logic masked;
        logic enable;
    } trap_state_type;

endpackage : ddr_trap_aging_pkg

// >>> cmd_aging_counter.sv
// transfer counter that requests a priority raise for the oldest command
`timescale 1ns/1ps
module cmd_aging_counter (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [7:0] aging_transfer_threshold,
    input  wire logic       xfer_done,
    input  wire logic       cmd_pending,
    output logic            raise_priority,
    output logic [7:0]      aging_count
);

    logic disabled;
    logic reached;

    // threshold decode
    assign disabled = (aging_transfer_threshold == ddr_trap_aging_pkg::THRESHOLD_DISABLED);
    assign reached  = (aging_count >= aging_transfer_threshold);

    ////////////////////////////////////////////////////////////////////////////////
    // count completed transfers, restart after the n+1-th
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aging_count <= ddr_trap_aging_pkg::COUNT_RESET;
        end else if (disabled) begin
            aging_count <= ddr_trap_aging_pkg::COUNT_RESET;
        end else if (xfer_done) begin
            if (reached) begin
                aging_count <= ddr_trap_aging_pkg::COUNT_RESET;
            end else begin
                aging_count <= aging_count + 8'h01;
            end
        end
    end

    // one-cycle raise pulse when the window closes with a command queued
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            raise_priority <= 1'b0;
        end else begin
            raise_priority <= !disabled && xfer_done && reached && cmd_pending;
        end
    end

endmodule : cmd_aging_counter

// >>> access_trap_status.sv
// raw and masked trap status with shared enable
`timescale 1ns/1ps
module access_trap_status (
    input  wire logic                              clk_sys,
    input  wire logic                              rst_b,
    input  wire logic                              trap_event,
    input  wire ddr_trap_aging_pkg::trap_ctrl_type ctrl,
    output ddr_trap_aging_pkg::trap_state_type     state
);

    logic raw;
    logic masked;
    logic enable;

    ////////////////////////////////////////////////////////////////////////////////
    // raw status: event wins over a same-cycle clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            raw <= 1'b0;
        end else if (trap_event) begin
            raw <= 1'b1;
        end else if (ctrl.clear_status) begin
            raw <= 1'b0;
        end
    end

    // masked status only while enabled
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            masked <= 1'b0;
        end else if (trap_event && enable) begin
            masked <= 1'b1;
        end else if (ctrl.clear_status) begin
            masked <= 1'b0;
        end
    end

    // shared enable, clear beats set
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            enable <= 1'b0;
        end else if (ctrl.enable_clear) begin
            enable <= 1'b0;
        end else if (ctrl.enable_set) begin
            enable <= 1'b1;
        end
    end

    // one driver for the whole state bundle
    assign state = {raw, masked, enable};

endmodule : access_trap_status

// >>> ddr_trap_aging.sv
// register file, aging unit and access trap of the memory controller
`timescale 1ns/1ps
module ddr_trap_aging (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        xfer_done,
    input  wire logic        cmd_pending,
    input  wire logic        trap_event,
    output logic             raise_priority,
    output logic             trap_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
        reg_hit = (addr == offset);
    endfunction : reg_hit

    function automatic logic bit_write(input logic [7:0] addr, input logic [7:0] offset,
                                       input logic wr, input logic [31:0] wdata);
        bit_write = wr && reg_hit(addr, offset) && wdata[ddr_trap_aging_pkg::TRAP_BIT];
    endfunction : bit_write

    ddr_trap_aging_pkg::reg_req_type    req;
    ddr_trap_aging_pkg::trap_ctrl_type  trap_ctrl;
    ddr_trap_aging_pkg::trap_state_type trap_state;
    logic [7:0]                         aging_transfer_threshold;
    logic [7:0]                         aging_count;
    logic [31:0]                        next_rdata;

    // bundle the bus request
    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    ////////////////////////////////////////////////////////////////////////////////
    // threshold register, reserved bits dropped
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aging_transfer_threshold <= ddr_trap_aging_pkg::THRESHOLD_RESET;
        end else if (req.wr && reg_hit(req.addr, ddr_trap_aging_pkg::OFF_AGING_THRESHOLD)) begin
            aging_transfer_threshold <= req.wdata[7:0];
        end
    end

    // write-one strobes toward the trap logic
    always_comb begin
        trap_ctrl.clear_status =
            bit_write(req.addr, ddr_trap_aging_pkg::OFF_TRAP_RAW, req.wr, req.wdata) ||
            bit_write(req.addr, ddr_trap_aging_pkg::OFF_TRAP_MASKED, req.wr, req.wdata);
        trap_ctrl.enable_set =
            bit_write(req.addr, ddr_trap_aging_pkg::OFF_TRAP_EN_SET, req.wr, req.wdata);
        trap_ctrl.enable_clear =
            bit_write(req.addr, ddr_trap_aging_pkg::OFF_TRAP_EN_CLEAR, req.wr, req.wdata);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux, only bit 2 of trap views
    always_comb begin
        next_rdata = ddr_trap_aging_pkg::RDATA_IDLE;
        if (req.rd) begin
            case (req.addr)
                ddr_trap_aging_pkg::OFF_AGING_THRESHOLD:
                    next_rdata = {24'h000000, aging_transfer_threshold};
                ddr_trap_aging_pkg::OFF_TRAP_RAW:
                    next_rdata[ddr_trap_aging_pkg::TRAP_BIT] = trap_state.raw;
                ddr_trap_aging_pkg::OFF_TRAP_MASKED:
                    next_rdata[ddr_trap_aging_pkg::TRAP_BIT] = trap_state.masked;
                ddr_trap_aging_pkg::OFF_TRAP_EN_SET,
                ddr_trap_aging_pkg::OFF_TRAP_EN_CLEAR:
                    next_rdata[ddr_trap_aging_pkg::TRAP_BIT] = trap_state.enable;
                default:
                    next_rdata = ddr_trap_aging_pkg::RDATA_IDLE;
            endcase
        end
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= ddr_trap_aging_pkg::RDATA_IDLE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // submodules
    cmd_aging_counter u_aging (
        .clk_sys                  (clk_sys),
        .rst_b                    (rst_b),
        .aging_transfer_threshold (aging_transfer_threshold),
        .xfer_done                (xfer_done),
        .cmd_pending              (cmd_pending),
        .raise_priority           (raise_priority),
        .aging_count              (aging_count)
    );

    access_trap_status u_trap (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .trap_event (trap_event),
        .ctrl       (trap_ctrl),
        .state      (trap_state)
    );

    // interrupt request follows masked status
    assign trap_irq = trap_state.masked;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence window_closes_s;
        xfer_done && cmd_pending && (aging_transfer_threshold != 8'hFF)
            && (aging_count == aging_transfer_threshold);
    endsequence

    sequence status_clear_s(logic [7:0] off);
        reg_wr && (reg_addr == off) && reg_wdata[2] && !trap_event;
    endsequence

    sequence status_keep_s(logic [7:0] off);
        reg_wr && (reg_addr == off) && !reg_wdata[2] && trap_state.raw;
    endsequence

    sequence enable_set_write_s;
        reg_wr && (reg_addr == 8'h0C) && reg_wdata[2];
    endsequence

    sequence enable_clear_write_s;
        reg_wr && (reg_addr == 8'h10) && reg_wdata[2];
    endsequence

    aging_fire_a: assert property (window_closes_s |=> raise_priority)
        else $error("priority raise missing after programmed transfers");

    aging_count_a: assert property (raise_priority |->
        $past(xfer_done) && ($past(aging_count) == $past(aging_transfer_threshold)))
        else $error("priority raise at wrong transfer count");

    aging_off_a: assert property ((aging_transfer_threshold == 8'hFF) |=> !raise_priority)
        else $error("priority raise while aging disabled");

    raw_set_a: assert property (trap_event |=> trap_state.raw ##1 trap_state.raw || trap_ctrl.clear_status || $past(trap_ctrl.clear_status))
        else $error("raw trap status not set by event");

    raw_clear_a: assert property (status_clear_s(8'h04) |=> !trap_state.raw && !trap_state.masked)
        else $error("raw trap write one did not clear both bits");

    raw_keep_a: assert property (status_keep_s(8'h04) |=> trap_state.raw)
        else $error("raw trap write zero changed status");

    masked_gate_a: assert property ($rose(trap_state.masked) |->
        $past(trap_state.enable) && $past(trap_event))
        else $error("masked trap set while disabled");

    masked_clear_a: assert property (status_clear_s(8'h08) |=> !trap_state.masked && !trap_state.raw)
        else $error("masked trap write one did not clear both bits");

    enable_views_a: assert property ((enable_set_write_s ##1 (reg_rd && reg_addr == 8'h10))
        |=> reg_rdata[2])
        else $error("enable not visible through clear view");

    enable_both_a: assert property ((trap_ctrl.enable_set && trap_ctrl.enable_clear)
        |=> !trap_state.enable)
        else $error("enable set despite concurrent clear");

    enable_clear_a: assert property ((enable_clear_write_s ##1 (reg_rd && reg_addr == 8'h0C))
        |=> !reg_rdata[2])
        else $error("set view reads one after clear");

    clear_write_a: assert property (enable_clear_write_s |=> !trap_state.enable)
        else $error("enable clear write ignored");

    irq_follow_a: assert property ((trap_event && trap_state.enable) |=> trap_irq[*1] ##0 trap_state.masked)
        else $error("interrupt request not raised by enabled trap");

    reserved_zero_a: assert property (reg_rd |=> (reg_rdata[31:8] == 24'h000000)
        && ($past(reg_addr) == 8'h00 || reg_rdata[7:0] == 8'h00 || reg_rdata[7:0] == 8'h04))
        else $error("reserved read bits not zero");

    idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside read answer cycle");

    ////////////////////////////////////////////////////////////////////////////////
    // further guards on counter, status hold and views
    sequence counting_xfer_s;
        xfer_done
            && (aging_transfer_threshold != ddr_trap_aging_pkg::THRESHOLD_DISABLED)
            && (aging_count < aging_transfer_threshold);
    endsequence

    sequence threshold_read_s;
        reg_rd && (reg_addr == ddr_trap_aging_pkg::OFF_AGING_THRESHOLD);
    endsequence

    count_step_a: assert property (counting_xfer_s |=>
        aging_count == $past(aging_count) + 8'h01)
        else $error("transfer count did not advance");

    count_held_a: assert property (
        (aging_transfer_threshold == ddr_trap_aging_pkg::THRESHOLD_DISABLED)
        |=> aging_count == ddr_trap_aging_pkg::COUNT_RESET)
        else $error("transfer count runs while aging disabled");

    raw_hold_a: assert property ((trap_state.raw && !trap_ctrl.clear_status)
        |=> trap_state.raw)
        else $error("raw trap status lost without clear");

    masked_hold_a: assert property ((trap_state.masked && !trap_ctrl.clear_status)
        |=> trap_state.masked)
        else $error("masked trap status lost without clear");

    irq_level_a: assert property (trap_irq == trap_state.masked)
        else $error("interrupt request differs from masked status");

    enable_hold_a: assert property ((!trap_ctrl.enable_set && !trap_ctrl.enable_clear)
        |=> $stable(trap_state.enable))
        else $error("enable changed without a write");

    set_write_a: assert property ((enable_set_write_s && !trap_ctrl.enable_clear)
        |=> trap_state.enable)
        else $error("enable set write ignored");

    threshold_view_a: assert property (threshold_read_s |=>
        reg_rdata == {24'h000000, $past(aging_transfer_threshold)})
        else $error("threshold read back wrong");

endmodule : ddr_trap_aging

// >>> cmd_source_model.sv
// bus master model issuing memory transfers toward the aging unit
`timescale 1ns/1ps
module cmd_source_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       start,
    input  wire logic [8:0] num_xfers,
    input  wire logic       slow,
    input  wire logic       hold_pending,
    output logic            xfer_done,
    output logic            cmd_pending,
    output logic            busy
);
    logic [8:0] left;
    logic       idle_tick;

    // one transfer a cycle, or every other cycle when slow
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            left      <= 9'h000;
            xfer_done <= 1'b0;
            idle_tick <= 1'b0;
        end else if (start) begin
            left      <= num_xfers;
            xfer_done <= 1'b0;
        end else if (left != 9'h000 && !(slow && !idle_tick)) begin
            xfer_done <= 1'b1;
            left      <= left - 9'h001;
            idle_tick <= 1'b0;
        end else begin
            xfer_done <= 1'b0;
            idle_tick <= left != 9'h000;
        end
    end

    // queue stays occupied while asked to
    assign cmd_pending = hold_pending;
    assign busy        = (left != 9'h000) || xfer_done;
endmodule : cmd_source_model

// >>> ddr_trap_aging_bench.sv
// self-checking bench for the aging unit and the access trap registers
`timescale 1ns/1ps
module ddr_trap_aging_bench;
    logic        clk_sys, rst_b, reg_wr, reg_rd, trap_event, raise_priority, trap_irq;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        xfer_done, cmd_pending, start, slow, hold_pending, busy;
    logic [8:0]  num_xfers;
    int          num_errors, n_compared, pulses, k;

    ddr_trap_aging dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .xfer_done(xfer_done), .cmd_pending(cmd_pending), .trap_event(trap_event),
        .raise_priority(raise_priority), .trap_irq(trap_irq));
    cmd_source_model master (.clk_sys(clk_sys), .rst_b(rst_b), .start(start),
        .num_xfers(num_xfers), .slow(slow), .hold_pending(hold_pending),
        .xfer_done(xfer_done), .cmd_pending(cmd_pending), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, pulse counter and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (raise_priority === 1'b1) pulses++;
    initial begin
        #(25ns * 60000);
        num_errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task automatic do_reset();
        @(posedge clk_sys) rst_b <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 check(name, reg_rdata, exp);
    endtask : rd
    task automatic trap_pulse();
        @(posedge clk_sys) trap_event <= 1'b1;
        @(posedge clk_sys) trap_event <= 1'b0;
    endtask : trap_pulse
    task automatic trap_view(input logic raw, input logic en, input string name);
        rd(ddr_trap_aging_pkg::OFF_TRAP_RAW, {29'h0, raw, 2'h0}, name);
        rd(ddr_trap_aging_pkg::OFF_TRAP_MASKED, {29'h0, raw & en, 2'h0}, name);
        rd(ddr_trap_aging_pkg::OFF_TRAP_EN_SET, {29'h0, en, 2'h0}, name);
        rd(ddr_trap_aging_pkg::OFF_TRAP_EN_CLEAR, {29'h0, en, 2'h0}, name);
        check("irq", {31'h0, trap_irq}, {31'h0, raw & en});
    endtask : trap_view
    function automatic int exp_pulses(input logic [7:0] thr, input int n, input logic pend);
        if (thr == 8'hFF || !pend) return 0;
        return n / (thr + 1);
    endfunction : exp_pulses
    task automatic aging(input logic [7:0] thr, input int n, input logic s, input logic p);
        do_reset();
        wr(ddr_trap_aging_pkg::OFF_AGING_THRESHOLD, {24'hABCDEF, thr});
        rd(ddr_trap_aging_pkg::OFF_AGING_THRESHOLD, {24'h0, thr}, "threshold");
        {slow, hold_pending, num_xfers} <= {s, p, n[8:0]};
        pulses = 0;
        @(posedge clk_sys) start <= 1'b1;
        @(posedge clk_sys) start <= 1'b0;
        for (k = 0; k < 700 && (k == 0 || busy !== 1'b0); k++) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        check("raise count", pulses, exp_pulses(thr, n, p));
        $display("aging test threshold %h transfers %0d done", thr, n);
    endtask : aging

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_b, reg_wr, reg_rd, trap_event, start, slow, hold_pending} = 7'h00;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h00000000;
        num_xfers  = 9'h000;
        num_errors = 0;
        n_compared = 0;
        pulses     = 0;
        void'($urandom(32'hCF1A975D));
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(ddr_trap_aging_pkg::OFF_AGING_THRESHOLD, 32'h000000FF, "threshold reset");
        trap_view(1'b0, 1'b0, "trap reset");
        wr(8'h14, 32'hFFFFFFFF);
        rd(8'h14, 32'h00000000, "unmapped");
        $display("reset test done");
        // corner thresholds, then random ones
        aging(8'h00, 5, 1'b0, 1'b1);
        aging(8'h01, 7, 1'b1, 1'b1);
        aging(8'hFE, 255, 1'b0, 1'b1);
        aging(8'hFF, 300, 1'b0, 1'b1);
        aging(8'h02, 9, 1'b0, 1'b0);
        repeat (6) aging(8'($urandom % 8), $urandom % 40, 1'($urandom), 1'b1);
        // trap while disabled, then clear paths
        trap_pulse();
        trap_view(1'b1, 1'b0, "trap disabled");
        wr(ddr_trap_aging_pkg::OFF_TRAP_RAW, 32'hFFFFFFFB);
        trap_view(1'b1, 1'b0, "raw write zero");
        wr(ddr_trap_aging_pkg::OFF_TRAP_RAW, 32'h00000004);
        trap_view(1'b0, 1'b0, "raw clear");
        wr(ddr_trap_aging_pkg::OFF_TRAP_EN_SET, 32'hFFFFFFFB);
        trap_view(1'b0, 1'b0, "set write zero");
        wr(ddr_trap_aging_pkg::OFF_TRAP_EN_SET, 32'h00000004);
        trap_view(1'b0, 1'b1, "enabled");
        trap_pulse();
        trap_view(1'b1, 1'b1, "trap enabled");
        wr(ddr_trap_aging_pkg::OFF_TRAP_MASKED, 32'h00000000);
        trap_view(1'b1, 1'b1, "masked write zero");
        wr(ddr_trap_aging_pkg::OFF_TRAP_MASKED, 32'hFFFFFFFF);
        trap_view(1'b0, 1'b1, "masked clear");
        trap_pulse();
        wr(ddr_trap_aging_pkg::OFF_TRAP_RAW, 32'h00000004);
        trap_view(1'b0, 1'b1, "raw clears masked");
        wr(ddr_trap_aging_pkg::OFF_TRAP_EN_CLEAR, 32'h00000000);
        trap_view(1'b0, 1'b1, "clear write zero");
        wr(ddr_trap_aging_pkg::OFF_TRAP_EN_CLEAR, 32'h00000004);
        trap_view(1'b0, 1'b0, "disabled");
        trap_pulse();
        trap_view(1'b1, 1'b0, "trap after disable");
        $display("trap test done");
        end_of_test();
    end
endmodule : ddr_trap_aging_bench
